// file: shared/mnrd_map.svh
// Purpose: Named offsets, encodings, field positions and reset values for the decoder
// Assumes: Included by bare name from the package and from every design file
// Notes: Definitions only
`ifndef MNRD_MAP_SVH
`define MNRD_MAP_SVH
`define MNRD_PC_RESET 13'h0000
`define MNRD_PC_STEP 13'h0001
`define MNRD_W_RESET 8'h00
`define MNRD_ZERO_BYTE 8'h00
`define MNRD_OPC_MOVF 6'h08
`define MNRD_OPC_STORE 7'h01
`define MNRD_OPC_LOAD 4'hC
`define MNRD_OPC_IDLE_HI 7'h00
`define MNRD_OPC_IDLE_LO 5'h00
`define MNRD_OPC_RETINT 14'h0009
`define MNRD_DEST_BIT 7
`define MNRD_REG_CTRL 2'h0
`define MNRD_REG_STATUS 2'h1
`define MNRD_REG_PC 2'h2
`define MNRD_CTRL_RUN_BIT 0
`define MNRD_CTRL_IE_CLR_BIT 1
`define MNRD_CTRL_RESET 1'b0
`define MNRD_BUS_ZERO 32'h00000000
`endif

// file: shared/mnrd_pkg.sv
// Purpose: Types shared by the decoder core and its register slave
// Assumes: Constants come from mnrd_map.svh
// Notes: State machine codes are one-hot
`include "mnrd_map.svh"
package mnrd_pkg;
    typedef enum logic [1:0] {
        MNRD_ST_EXEC = 2'b01,
        MNRD_ST_FLUSH = 2'b10
    } mnrd_state_t;

    typedef enum logic [2:0] {
        MNRD_OP_OTHER,
        MNRD_OP_MOVF,
        MNRD_OP_STORE,
        MNRD_OP_LOAD,
        MNRD_OP_IDLE,
        MNRD_OP_RETINT
    } mnrd_op_t;

    // File register write port
    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } mnrd_file_wr_t;

    // Core state seen by software
    typedef struct packed {
        logic run;
        logic busy;
        logic int_en;
        logic zero;
        logic [7:0] w;
        logic [12:0] pc;
    } mnrd_status_t;

    typedef struct packed {
        mnrd_state_t state;
        logic [12:0] pc;
        logic [7:0] w;
        logic zero;
        logic int_en;
        mnrd_file_wr_t wr;
    } mnrd_core_state_t;

    typedef struct packed {
        logic ack;
        logic run;
        logic int_en_clr;
        logic [31:0] rdata;
    } mnrd_bus_state_t;
endpackage : mnrd_pkg

// file: verilog/mnrd_bus_regs.sv
// Purpose: Avalon-MM slave holding control and showing core status
// Assumes: Word addressing, one wait state on every access
// Notes: Unmapped reads return zero, unmapped writes are dropped
`timescale 1ns/10ps
`default_nettype none
`include "mnrd_map.svh"
module mnrd_bus_regs (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire mnrd_pkg::mnrd_status_t status_in,
    output logic run_out,
    output logic int_en_clr_out
);
    import mnrd_pkg::*;

    mnrd_bus_state_t cur_reg;
    mnrd_bus_state_t cur_next;
    logic req;

    // First cycle of a request waits, second one answers
    assign req = avs_read_in | avs_write_in;
    assign avs_waitrequest_out = req & ~cur_reg.ack;
    assign avs_readdata_out = cur_reg.rdata;
    assign run_out = cur_reg.run;
    assign int_en_clr_out = cur_reg.int_en_clr;

    // Read data is captured in the wait cycle so it stands when waitrequest drops
    always_comb begin
        cur_next = cur_reg;
        cur_next.ack = req & ~cur_reg.ack;
        cur_next.int_en_clr = 1'b0;
        if (avs_read_in && !cur_reg.ack) begin
            case (avs_address_in)
                `MNRD_REG_CTRL: cur_next.rdata = {31'h00000000, cur_reg.run};
                `MNRD_REG_STATUS: cur_next.rdata = {20'h00000, status_in.run, status_in.busy,
                                                    status_in.int_en, status_in.zero,
                                                    status_in.w};
                `MNRD_REG_PC: cur_next.rdata = {19'h00000, status_in.pc};
                default: cur_next.rdata = `MNRD_BUS_ZERO;
            endcase
        end
        // Write lands only at the edge where waitrequest is low
        if (avs_write_in && cur_reg.ack && avs_address_in == `MNRD_REG_CTRL) begin
            cur_next.run = avs_writedata_in[`MNRD_CTRL_RUN_BIT];
            cur_next.int_en_clr = avs_writedata_in[`MNRD_CTRL_IE_CLR_BIT];
        end
        if (!rst_n_in) begin
            cur_next = '{ack: 1'b0, run: `MNRD_CTRL_RESET, int_en_clr: 1'b0,
                         rdata: `MNRD_BUS_ZERO};
        end
    end

    // State register
    always_ff @(posedge clk_in) begin
        cur_reg <= cur_next;
    end
endmodule : mnrd_bus_regs
`default_nettype wire

// file: verilog/mnrd_core.sv
// Purpose: Decode and execute file move, store, literal load, no-op and interrupt return
// Assumes: Program memory presents the word at pc_out; file read is combinational
// Notes: One instruction cycle per clock; interrupt return stalls fetch one cycle
// Operation
// - File move copies register to W when d is 0, back to itself when 1
// - File move sets zero flag from the moved value
// - Store writes W into the addressed file register, flags untouched
// - Literal load puts the 8-bit immediate into W, flags untouched
// - Don't-care bits of literal load are zero from producers, ignored here
// - Interrupt return pops stack, loads program counter from stack top
// - Interrupt return sets global interrupt enable
// - Interrupt return is one word, two cycles, no flags changed
`timescale 1ns/10ps
`default_nettype none
`include "mnrd_map.svh"
module mnrd_core (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [13:0] instr_word_in,
    input wire logic instr_valid_in,
    output logic instr_ready_out,
    output logic [12:0] pc_out,
    output logic [6:0] file_raddr_out,
    input wire logic [7:0] file_rdata_in,
    output mnrd_pkg::mnrd_file_wr_t file_wr_out,
    input wire logic [12:0] stack_top_in,
    output logic stack_pop_out,
    output logic [7:0] w_out,
    output logic zero_out,
    output logic global_interrupt_enable_out,
    input wire logic [1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out
);
    import mnrd_pkg::*;

    mnrd_core_state_t cur_reg;
    mnrd_core_state_t cur_next;
    mnrd_status_t status;
    mnrd_op_t op;
    logic fire;
    logic run;
    logic int_en_clr;
    logic [7:0] move_val;

    // Classify one instruction word; masked bits are don't-care
    function automatic mnrd_op_t mnrd_decode(input logic [13:0] iw);
        mnrd_op_t res;
        res = MNRD_OP_OTHER;
        if (iw == `MNRD_OPC_RETINT) begin
            res = MNRD_OP_RETINT;
        end else if (iw[13:8] == `MNRD_OPC_MOVF) begin
            res = MNRD_OP_MOVF;
        end else if (iw[13:7] == `MNRD_OPC_STORE) begin
            res = MNRD_OP_STORE;
        end else if (iw[13:10] == `MNRD_OPC_LOAD) begin
            res = MNRD_OP_LOAD;
        end else if (iw[13:7] == `MNRD_OPC_IDLE_HI && iw[4:0] == `MNRD_OPC_IDLE_LO) begin
            res = MNRD_OP_IDLE;
        end
        return res;
    endfunction : mnrd_decode

    // Register slave for run control and status readback
    mnrd_bus_regs u_regs (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in),
        .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out),
        .status_in(status),
        .run_out(run),
        .int_en_clr_out(int_en_clr)
    );

    // Fetch is held off while stopped and in the second cycle of a return
    assign instr_ready_out = run && cur_reg.state == MNRD_ST_EXEC;
    assign fire = instr_valid_in && instr_ready_out;
    assign op = mnrd_decode(instr_word_in);
    assign file_raddr_out = instr_word_in[6:0];
    // Bypass the write still held on the port, else a back-to-back read sees stale data
    assign move_val = (cur_reg.wr.we && cur_reg.wr.addr == instr_word_in[6:0]) ?
                      cur_reg.wr.data : file_rdata_in;

    // Outputs straight from state
    assign pc_out = cur_reg.pc;
    assign w_out = cur_reg.w;
    assign zero_out = cur_reg.zero;
    assign global_interrupt_enable_out = cur_reg.int_en;
    assign file_wr_out = cur_reg.wr;
    assign stack_pop_out = cur_reg.state == MNRD_ST_FLUSH;
    assign status = '{run: run, busy: cur_reg.state == MNRD_ST_FLUSH, int_en: cur_reg.int_en,
                      zero: cur_reg.zero, w: cur_reg.w, pc: cur_reg.pc};

    // Next state; unknown words are retired like a no-op
    always_comb begin
        cur_next = cur_reg;
        cur_next.wr.we = 1'b0;
        if (int_en_clr) begin
            cur_next.int_en = 1'b0; // Return below overrides, so a set wins
        end
        case (cur_reg.state)
            MNRD_ST_EXEC: begin
                if (fire) begin
                    cur_next.pc = cur_reg.pc + `MNRD_PC_STEP;
                    case (op)
                        MNRD_OP_MOVF: begin
                            cur_next.zero = move_val == `MNRD_ZERO_BYTE;
                            if (instr_word_in[`MNRD_DEST_BIT]) begin
                                cur_next.wr = '{we: 1'b1, addr: instr_word_in[6:0],
                                                data: move_val};
                            end else begin
                                cur_next.w = move_val;
                            end
                        end
                        MNRD_OP_STORE: begin
                            cur_next.wr = '{we: 1'b1, addr: instr_word_in[6:0],
                                            data: cur_reg.w};
                        end
                        MNRD_OP_LOAD: begin
                            cur_next.w = instr_word_in[7:0];
                        end
                        MNRD_OP_RETINT: begin
                            cur_next.pc = stack_top_in;
                            cur_next.int_en = 1'b1;
                            cur_next.state = MNRD_ST_FLUSH;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            MNRD_ST_FLUSH: begin
                cur_next.state = MNRD_ST_EXEC;
            end
            default: begin
                cur_next.state = MNRD_ST_EXEC;
            end
        endcase
        if (!rst_n_in) begin
            cur_next = '{state: MNRD_ST_EXEC, pc: `MNRD_PC_RESET, w: `MNRD_W_RESET, zero: 1'b0,
                         int_en: 1'b0, wr: '{we: 1'b0, addr: 7'h00, data: `MNRD_ZERO_BYTE}};
        end
    end

    // State register
    always_ff @(posedge clk_in) begin
        cur_reg <= cur_next;
    end

    // Checks on the decoded behaviour
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    a_movf_to_w: assert property (
        fire && op == MNRD_OP_MOVF && !instr_word_in[`MNRD_DEST_BIT]
        |=> w_out == $past(move_val) && !file_wr_out.we)
        else $error("file move to W lost the value");

    a_movf_back: assert property (
        fire && op == MNRD_OP_MOVF && instr_word_in[`MNRD_DEST_BIT]
        |=> file_wr_out.we && file_wr_out.addr == $past(instr_word_in[6:0])
            && file_wr_out.data == $past(move_val) && $stable(w_out))
        else $error("file move write-back wrong");

    a_movf_zero: assert property (
        fire && op == MNRD_OP_MOVF |=> zero_out == ($past(move_val) == `MNRD_ZERO_BYTE))
        else $error("zero flag not from moved value");

    a_store_write: assert property (
        fire && op == MNRD_OP_STORE
        |=> file_wr_out.we && file_wr_out.data == $past(w_out) && $stable(zero_out))
        else $error("store of W wrong");

    a_load_literal: assert property (
        fire && op == MNRD_OP_LOAD |=> w_out == $past(instr_word_in[7:0]) && $stable(zero_out))
        else $error("literal load wrong");

    a_literal_dontcare: assert property (
        instr_word_in[13:10] == `MNRD_OPC_LOAD |-> op == MNRD_OP_LOAD)
        else $error("literal don't-care bits decoded");

    a_return_pc: assert property (
        fire && op == MNRD_OP_RETINT |=> pc_out == $past(stack_top_in) && stack_pop_out
        ##1 !stack_pop_out)
        else $error("return did not load stack top once");

    a_return_int_en: assert property (
        fire && op == MNRD_OP_RETINT |=> global_interrupt_enable_out)
        else $error("return left interrupts disabled");

    a_return_two: assert property (
        fire && op == MNRD_OP_RETINT |=> (!instr_ready_out && $stable(zero_out))
        ##1 (cur_reg.state == MNRD_ST_EXEC && $stable(zero_out)))
        else $error("return not two cycles");

    a_idle_quiet: assert property (
        fire && op == MNRD_OP_IDLE
        |=> pc_out == $past(pc_out) + `MNRD_PC_STEP && $stable(w_out) && $stable(zero_out)
            && !file_wr_out.we)
        else $error("no-op changed state");

    a_single_cycle: assert property (
        fire && (op == MNRD_OP_MOVF || op == MNRD_OP_STORE || op == MNRD_OP_LOAD)
        |=> pc_out == $past(pc_out) + `MNRD_PC_STEP && cur_reg.state == MNRD_ST_EXEC)
        else $error("single-cycle op stalled");
endmodule : mnrd_core
`default_nettype wire

// file: tb/mnrd_prog_mem.sv
// Purpose: Program memory model feeding instruction words to the core
// Assumes: Word index is the low five bits of the program counter
// Notes: Slow mode withholds valid on every other cycle
`timescale 1ns/10ps
`default_nettype none
module mnrd_prog_mem (
    input wire logic clk_in,
    input wire logic slow_in,
    input wire logic [12:0] pc_in,
    output logic [13:0] word_out,
    output logic valid_out
);
    logic [13:0] mem [0:31];
    logic gap_reg = 1'b0;

    // Toggle that stretches each fetch when the memory is slow
    always @(posedge clk_in) begin
        gap_reg <= ~gap_reg;
    end

    // Words pass as the bench stores them; one literal sets spare bits to prove they are ignored
    // A withheld word shows its inverse so stale data cannot pass as valid
    assign valid_out = ~(slow_in & gap_reg);
    assign word_out = valid_out ? mem[pc_in[4:0]] : ~mem[pc_in[4:0]];
endmodule : mnrd_prog_mem
`default_nettype wire

// file: tb/mnrd_core_tb.sv
// Purpose: Self-checking bench for the move, literal, no-op and return decoder
// Assumes: Register bus answers with one wait state
// Notes: File registers and return stack top are modelled here
`timescale 1ns/10ps
`default_nettype none
module mnrd_core_tb;
    import mnrd_pkg::*;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic slow = 1'b0;
    logic [13:0] word;
    logic valid, ready, pop, zero, int_en, av_wait;
    logic [6:0] last_waddr = 7'h00;
    logic [12:0] pc;
    logic [12:0] stack_top = 13'h0010;
    logic [6:0] raddr;
    logic [7:0] w;
    logic [7:0] fmem [0:127];
    mnrd_file_wr_t fwr;
    logic [1:0] av_addr = 2'h0;
    logic av_rd = 1'b0;
    logic av_wr = 1'b0;
    logic [31:0] av_wd = 32'h00000000;
    logic [31:0] av_rdata;
    int bad_count = 0;
    int samples_checked = 0;
    int pops = 0;

    // Clock at 25 MHz
    always #20 clk_in = ~clk_in;

    // File registers take a write at the edge ending its pulse; pops counted
    always @(posedge clk_in) begin
        if (fwr.we === 1'b1) begin
            fmem[fwr.addr] <= fwr.data;
            last_waddr <= fwr.addr;
        end
        if (pop === 1'b1) pops <= pops + 1;
    end

    mnrd_prog_mem PM (.clk_in(clk_in), .slow_in(slow), .pc_in(pc), .word_out(word),
        .valid_out(valid));

    mnrd_core DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .instr_word_in(word),
        .instr_valid_in(valid), .instr_ready_out(ready), .pc_out(pc),
        .file_raddr_out(raddr), .file_rdata_in(fmem[raddr]), .file_wr_out(fwr),
        .stack_top_in(stack_top), .stack_pop_out(pop), .w_out(w), .zero_out(zero),
        .global_interrupt_enable_out(int_en), .avs_address_in(av_addr), .avs_read_in(av_rd),
        .avs_write_in(av_wr), .avs_writedata_in(av_wd), .avs_readdata_out(av_rdata),
        .avs_waitrequest_out(av_wait));

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Holds the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [1:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk_in);
        av_addr <= a;
        av_wr <= wr;
        av_rd <= ~wr;
        av_wd <= d;
        do @(posedge clk_in); while (av_wait !== 1'b0);
        q = av_rdata;
        av_wr <= 1'b0;
        av_rd <= 1'b0;
    endtask : bus

    task automatic do_reset();
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (12) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        pops = 0;
        for (int i = 0; i < 32; i++) begin
            PM.mem[i] = 14'h0000;
        end
    endtask : do_reset

    // Sets run, counts cycles until pc reaches target, then stops
    task automatic run_to(input logic [12:0] target, output int n);
        logic [31:0] q;
        bus(1'b1, 2'h0, 32'h1, q);
        for (n = 0; n < 200 && pc !== target; n++) begin
            @(posedge clk_in);
            #1;
        end
        chk("pc reached", {3'h0, target}, {3'h0, pc});
        bus(1'b1, 2'h0, 32'h0, q);
    endtask : run_to

    task automatic t_reset();
        logic [31:0] q;
        do_reset();
        chk("pc", 16'h0000, {3'h0, pc});
        chk("w zero int_en ready", 16'h0000, {5'h00, w, zero, int_en, ready});
        bus(1'b1, 2'h3, 32'hFFFFFFFF, q);
        bus(1'b0, 2'h3, 32'h00000000, q);
        chk("unmapped read", 16'h0000, q[15:0]);
        bus(1'b0, 2'h0, 32'h00000000, q);
        chk("ctrl read", 16'h0000, q[15:0]);
    endtask : t_reset

    // Program of file moves, stores, loads and a no-op with its loose bits set
    task automatic t_moves(input logic slow_mode);
        logic [13:0] prog [0:7];
        int n;
        prog = '{14'h305A, 14'h00A0, 14'h3300, 14'h00A2, 14'h0820, 14'h00A3, 14'h08A1,
            14'h0060};
        do_reset();
        slow <= slow_mode;
        fmem[7'h20] = 8'h11;
        fmem[7'h21] = 8'h00;
        fmem[7'h22] = 8'h33;
        fmem[7'h23] = 8'h33;
        last_waddr = 7'h00;
        for (int i = 0; i < 8; i++) begin
            PM.mem[i] = prog[i];
        end
        run_to(13'h0008, n);
        if (!slow_mode) chk("cycles", 16'h0008, n[15:0]);
        chk("stored w", 16'h005A, {8'h00, fmem[7'h20]});
        chk("loose literal", 16'h0000, {8'h00, fmem[7'h22]});
        chk("move to w", 16'h005A, {8'h00, fmem[7'h23]});
        chk("w", 16'h005A, {8'h00, w});
        chk("zero test", 16'h0001, {15'h0000, zero});
        chk("written back", 16'h0000, {8'h00, fmem[7'h21]});
        chk("last write addr", 16'h0021, {9'h000, last_waddr});
    endtask : t_moves

    // Interrupt return: stack top into pc, interrupt enable set, one stalled cycle
    task automatic t_retint();
        logic [31:0] q;
        do_reset();
        slow <= 1'b0;
        PM.mem[0] = 14'h3081;
        PM.mem[1] = 14'h0009;
        bus(1'b1, 2'h0, 32'h1, q);
        repeat (2) @(posedge clk_in);
        #1;
        chk("pc after return", 16'h0010, {3'h0, pc});
        chk("int_en pop ready", 16'h0006, {13'h0000, int_en, pop, ready});
        @(posedge clk_in);
        #1;
        chk("second cycle", 16'h0021, {2'h0, pc, ready});
        // Three no-ops retire up to the edge where the stop write lands after its wait state
        bus(1'b1, 2'h0, 32'h0, q);
        chk("w zero", 16'h0205, {6'h00, w, zero, pops[0]});
        bus(1'b0, 2'h1, 32'h0, q);
        chk("status read", 16'h0281, q[15:0]);
        bus(1'b0, 2'h2, 32'h0, q);
        chk("pc read", 16'h0013, q[15:0]);
        bus(1'b1, 2'h0, 32'h2, q);
        repeat (3) @(posedge clk_in);
        chk("int_en cleared", 16'h0000, {15'h0000, int_en});
    endtask : t_retint

    task automatic stop_test();
        $display("Checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    // Cuts a hang short after far more than the tests need
    initial begin
        #200000;
        bad_count++;
        stop_test();
    end

    initial begin
        t_reset();
        t_moves(1'b0);
        t_moves(1'b1);
        t_retint();
        stop_test();
    end
endmodule : mnrd_core_tb
`default_nettype wire
